// ===== verilog/fcs_flash_checker.sv
// Flash checker: scans a flash section, computes a CRC and checks the stored checksum.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
module fcs_flash_checker #(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Avalon-MM register slave
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [7:0] avs_writedata,
   output logic [7:0] avs_readdata,
   output logic avs_waitrequest,
   // Reset-time scan request and setup
   input wire logic init_scan_req,
   input wire fcs_pkg::fcs_setup_type init_setup,
   // Section limits in bytes, last byte address of each section
   input wire logic [ADDR_W-1:0] boot_section_limit,
   input wire logic [ADDR_W-1:0] app_section_limit,
   input wire logic [ADDR_W-1:0] last_program_address,
   // Flash read port
   output logic flash_req,
   output logic [ADDR_W-1:0] flash_addr,
   input wire logic flash_valid,
   input wire logic [15:0] flash_rdata,
   // CPU side
   input wire logic cpu_sleep,
   output logic cpu_stall,
   output logic cpu_start_block,
   output logic nmi_req
);
   import fcs_pkg::*;

   // ********************************************************************
   // CRC step over one byte, most significant bit first
   // ********************************************************************
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = (r[15] ^ b[i]) ? ((r << 1) ^ FCS_CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   // ********************************************************************
   // State
   // ********************************************************************
   fcs_state_type state_reg, state_next;
   logic enable_reg, fail_nmi_enable_reg, pass_reg, nmi_reg, init_reg;
   fcs_setup_type setup_reg;
   logic [1:0] cnt_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [15:0] crc_reg, stored_reg;
   logic sreset_reg, pend_reg, init_done_reg, ack_reg;
   logic [7:0] rdata_reg;

   wire busy = (state_reg != FCS_IDLE);
   wire acc = (avs_read | avs_write) & ~ack_reg;
   // A write lands at the edge where waitrequest is seen low, as the bus master expects.
   wire wr = avs_write & ack_reg;
   wire wr_ctl = wr & (avs_address == FCS_OFF_CONTROL) & ~nmi_reg;
   wire wr_set = wr & (avs_address == FCS_OFF_SETUP) & ~busy & ~nmi_reg;
   wire sreset_ok = wr_ctl & avs_writedata[FCS_CTL_SRESET] & (~fail_nmi_enable_reg | ~busy);
   wire start_sw = wr_ctl & avs_writedata[FCS_CTL_ENABLE] & ~avs_writedata[FCS_CTL_SRESET];
   wire start_init = init_scan_req & ~init_done_reg;
   wire [ADDR_W-1:0] sec_end = (setup_reg.section == FCS_SEC_BOOT) ? boot_section_limit :
                               (setup_reg.section == FCS_SEC_BOOT_PLUS_APP_CODE) ? app_section_limit :
                               last_program_address;
   wire [ADDR_W-1:0] word_last = sec_end - ADDR_W'(1);
   wire at_end = (addr_reg >= word_last - ADDR_W'(1));
   wire fetch_word = (state_reg == FCS_SCAN) & flash_valid & ~cpu_sleep;
   wire is_tail = (addr_reg >= word_last);
   wire [15:0] crc_step = crc_byte(crc_byte(crc_reg, flash_rdata[7:0]), flash_rdata[15:8]);
   wire match = (crc_reg == stored_reg);
   wire [7:0] ctl_rd = {6'h00, fail_nmi_enable_reg, enable_reg};
   wire [7:0] set_rd = {2'h0, setup_reg.mode, 2'h0, setup_reg.section};
   wire [7:0] sta_rd = {6'h00, pass_reg & ~busy, busy};
   wire [7:0] rd_mux = (avs_address == FCS_OFF_CONTROL) ? ctl_rd :
                       (avs_address == FCS_OFF_SETUP) ? set_rd :
                       (avs_address == FCS_OFF_STATE) ? sta_rd : 8'h00;

   // ********************************************************************
   // Sequencer
   // ********************************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         FCS_IDLE: begin
            if (start_init) begin
               state_next = FCS_SCAN;
            end else if (start_sw) begin
               state_next = FCS_DELAY;
            end
         end
         FCS_DELAY: begin
            if (cnt_reg == 2'(FCS_START_DELAY - 1) && !cpu_sleep) begin
               state_next = FCS_SCAN;
            end
         end
         FCS_SCAN: begin
            if (fetch_word && is_tail) begin
               state_next = FCS_CHECK;
            end
         end
         FCS_CHECK: state_next = FCS_IDLE;
         default: state_next = FCS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst || sreset_reg) begin
         state_reg <= FCS_IDLE;
         enable_reg <= 1'b0;
         setup_reg <= '0;
         pass_reg <= 1'b1;
         cnt_reg <= 2'h0;
         addr_reg <= '0;
         crc_reg <= FCS_CRC_INIT;
         stored_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         if (wr_set) begin
            setup_reg <= fcs_setup_type'({avs_writedata[FCS_SET_MODE_LO +: 2],
                                         avs_writedata[FCS_SET_SEC_LO +: 2]});
         end else if (start_init && state_reg == FCS_IDLE) begin
            setup_reg <= fcs_setup_type'({FCS_MODE_RESETSCAN, init_setup.section});
         end
         if (start_init && state_reg == FCS_IDLE) begin
            enable_reg <= 1'b1;
         end else if (wr_ctl && !avs_writedata[FCS_CTL_SRESET]) begin
            enable_reg <= avs_writedata[FCS_CTL_ENABLE];
         end
         if (state_reg == FCS_IDLE && (start_sw || start_init)) begin
            pass_reg <= 1'b0;
            cnt_reg <= 2'h0;
            addr_reg <= '0;
            crc_reg <= FCS_CRC_INIT;
         end else if (state_reg == FCS_DELAY && !cpu_sleep) begin
            cnt_reg <= cnt_reg + 2'h1;
         end else if (state_reg == FCS_SCAN && !cpu_sleep) begin
            cnt_reg <= (cnt_reg == 2'(FCS_FETCH_PERIOD - 1)) ? 2'h0 : cnt_reg + 2'h1;
            if (fetch_word) begin
               addr_reg <= addr_reg + ADDR_W'(2);
               if (is_tail) begin
                  stored_reg <= {flash_rdata[7:0], flash_rdata[15:8]};
               end else begin
                  crc_reg <= crc_step;
               end
            end
         end else if (state_reg == FCS_CHECK) begin
            pass_reg <= match;
         end
      end
   end

   // ********************************************************************
   // NMI and reset-time bookkeeping; not cleared by the self-reset strobe
   // ********************************************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         fail_nmi_enable_reg <= 1'b0;
         nmi_reg <= 1'b0;
         init_reg <= 1'b0;
         init_done_reg <= 1'b0;
         sreset_reg <= 1'b0;
      end else begin
         sreset_reg <= sreset_ok;
         if (wr_ctl && avs_writedata[FCS_CTL_FAIL_NMI_ENABLE] && !busy) begin
            fail_nmi_enable_reg <= 1'b1;
         end
         if (!pass_reg && fail_nmi_enable_reg && !busy) begin
            nmi_reg <= 1'b1;
         end
         if (start_init && state_reg == FCS_IDLE) begin
            init_reg <= 1'b1;
            init_done_reg <= 1'b1;
         end else if (state_reg == FCS_CHECK && match) begin
            init_reg <= 1'b0;
         end
      end
   end

   // ********************************************************************
   // Registered outputs and bus answer
   // ********************************************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ack_reg <= 1'b0;
         avs_waitrequest <= 1'b1;
         rdata_reg <= 8'h00;
         flash_req <= 1'b0;
         flash_addr <= '0;
         cpu_stall <= 1'b0;
         cpu_start_block <= 1'b0;
         nmi_req <= 1'b0;
         pend_reg <= 1'b0;
      end else begin
         ack_reg <= acc;
         avs_waitrequest <= ~acc;
         rdata_reg <= rd_mux;
         flash_req <= (state_next == FCS_SCAN) && !cpu_sleep &&
                      ((state_reg != FCS_SCAN) || (cnt_reg == 2'(FCS_FETCH_PERIOD - 1))) &&
                      !(fetch_word && is_tail);
         flash_addr <= fetch_word ? addr_reg + ADDR_W'(2) : addr_reg;
         cpu_stall <= (state_next == FCS_SCAN) || (state_next == FCS_CHECK) || pend_reg;
         pend_reg <= (state_reg == FCS_DELAY) && cpu_sleep ? 1'b1 :
                     (state_next == FCS_IDLE) ? 1'b0 : pend_reg;
         cpu_start_block <= init_reg && (state_next != FCS_IDLE || !pass_reg);
         nmi_req <= nmi_reg;
      end
   end
   assign avs_readdata = rdata_reg;
   wire unused_ok = at_end;

   // ********************************************************************
   // Checks
   // ********************************************************************
   sequence enable_write_s;
      wr_ctl && avs_writedata[FCS_CTL_ENABLE] && !avs_writedata[FCS_CTL_SRESET] && !busy && !start_init;
   endsequence
   start_delay_a: assert property (@(posedge core_clk) disable iff (sys_rst || sreset_reg)
      enable_write_s ##1 !cpu_sleep [*3] |=> state_reg == FCS_SCAN)
      else $error("scan did not start after delay");
   nmi_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      nmi_req |=> nmi_req)
      else $error("nmi request withdrawn");
   nmi_cause_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(nmi_reg) |-> $past(fail_nmi_enable_reg) && !$past(pass_reg))
      else $error("nmi without failure");
   ctl_lock_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      nmi_reg && !sreset_reg |=> $stable(enable_reg))
      else $error("control written after nmi");
   setup_lock_a: assert property (@(posedge core_clk) disable iff (sys_rst || sreset_reg)
      busy && state_reg != FCS_IDLE && !start_init |=> $stable(setup_reg))
      else $error("setup changed while busy");
   sreset_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      sreset_ok |=> ##1 !enable_reg && setup_reg == '0 && !busy)
      else $error("self reset did not clear");
   fail_nmi_enable_keep_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      fail_nmi_enable_reg |=> fail_nmi_enable_reg)
      else $error("nmi enable cleared");
   stall_scan_a: assert property (@(posedge core_clk) disable iff (sys_rst || sreset_reg)
      state_reg == FCS_SCAN && $past(state_reg) == FCS_SCAN |-> cpu_stall)
      else $error("cpu not stalled in scan");
   pass_busy_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      busy |-> !sta_rd[FCS_STA_PASS])
      else $error("pass reads one while busy");
   sleep_pause_a: assert property (@(posedge core_clk) disable iff (sys_rst || sreset_reg)
      cpu_sleep && state_reg == FCS_SCAN |=> $stable(addr_reg))
      else $error("scan advanced in sleep");
endmodule

// ===== verilog/fcs_pkg.sv
// Package with register map, field layout and timing constants of the flash checker.
//
// Behaviour
// - Software picks section, mode zero, sets enable; scan starts three cycles later.
// - A failed reset-time scan keeps the CPU from starting normal code.
// - After a reset-time scan enable reads one, mode non-zero, section as checked.
// - Priority mode owns flash and stalls the CPU until the scan completes.
// - Priority mode fetches one 16-bit flash word every third clock cycle.
// - Mismatch clears pass flag; NMI requested when not busy with pass clear and NMI enable set.
// - The NMI request stays until system reset; no write withdraws it.
// - The NMI reaches the CPU regardless of global interrupt enable.
// - NMI enable cleared only by system reset; set only while not busy.
// - The checker pauses in every sleep mode and resumes on wake.
// - Sleep in the start delay holds the start until wake; interrupts wait.
// - After an NMI all writes to the control register are ignored.
// - Setup writes are ignored while busy or after an NMI.
// - Self-reset strobe clears enable, setup and status one cycle later; NMI enable is kept.
// - Enable stays one after a scan; writing one again restarts a check.
// - Writing enable zero stops only after the current scan ends.
// - Mode zero is priority single check; other values reserved.
// - Section zero full flash, one boot plus app code, two boot only.
// - Busy bit shows whether a scan is in progress.
// - Checksum polynomial is x^16 + x^12 + x^5 + 1.
// - Checksum starts at all ones, bytes upward, most significant bit first.
// - Pass flag resets to one, clears on enable, reads zero while busy.
package fcs_pkg;
   // ********************************************************************
   // Register map
   // ********************************************************************
   localparam logic [1:0] FCS_OFF_CONTROL = 2'h0;
   localparam logic [1:0] FCS_OFF_SETUP = 2'h1;
   localparam logic [1:0] FCS_OFF_STATE = 2'h2;
   localparam int FCS_CTL_ENABLE = 0;
   localparam int FCS_CTL_FAIL_NMI_ENABLE = 1;
   localparam int FCS_CTL_SRESET = 7;
   localparam int FCS_SET_SEC_LO = 0;
   localparam int FCS_SET_MODE_LO = 4;
   localparam int FCS_STA_BUSY = 0;
   localparam int FCS_STA_PASS = 1;
   localparam logic [1:0] FCS_SEC_FULL = 2'h0;
   localparam logic [1:0] FCS_SEC_BOOT_PLUS_APP_CODE = 2'h1;
   localparam logic [1:0] FCS_SEC_BOOT = 2'h2;
   localparam logic [1:0] FCS_MODE_PRIORITY = 2'h0;
   localparam logic [1:0] FCS_MODE_RESETSCAN = 2'h1;
   // ********************************************************************
   // Timing and checksum
   // ********************************************************************
   localparam int FCS_START_DELAY = 3;
   localparam int FCS_FETCH_PERIOD = 3;
   localparam logic [15:0] FCS_CRC_INIT = 16'hffff;
   localparam logic [15:0] FCS_CRC_POLY = 16'h1021;
   localparam logic [7:0] FCS_SECTION_PAGE = 8'h00;
   typedef enum logic [1:0] {
      FCS_IDLE = 2'b00,
      FCS_DELAY = 2'b01,
      FCS_SCAN = 2'b11,
      FCS_CHECK = 2'b10
   } fcs_state_type;
   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] section;
   } fcs_setup_type;
endpackage

// ===== tb/fcs_flash_model.sv
// Flash model that answers each word request one cycle later from a byte array.
`timescale 1ns/1ps
module fcs_flash_model (
   // Clock
   input wire logic core_clk,
   // Word read port
   input wire logic flash_req,
   input wire logic [15:0] flash_addr,
   output logic flash_valid,
   output logic [15:0] flash_rdata
);
   logic [7:0] mem [64];
   initial flash_valid = 1'b0;
   initial flash_rdata = 16'h0000;
   // Idle data toggles every cycle, so a late sample never sees a stale word.
   always @(posedge core_clk) begin
      flash_valid <= flash_req;
      flash_rdata <= flash_req ? {mem[flash_addr[5:0] + 6'h01], mem[flash_addr[5:0]]} : ~flash_rdata;
   end
endmodule

// ===== tb/test_flash_crc_scanner.sv
// Self-checking bench for the flash checker with a flash model on its read port.
`timescale 1ns/1ps
module test_flash_crc_scanner;
   import fcs_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [1:0] avs_address = 2'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [7:0] avs_writedata = 8'h00;
   logic [7:0] avs_readdata;
   logic avs_waitrequest;
   logic init_scan_req = 1'b0;
   fcs_setup_type init_setup = 4'h1;
   logic cpu_sleep = 1'b0;
   logic flash_req, flash_valid, cpu_stall, cpu_start_block, nmi_req;
   logic [15:0] flash_addr, flash_rdata;
   int n_fail = 0;
   int comparisons = 0;
   int nreq = 0;
   int gap = 9;
   always #10 core_clk = ~core_clk;
   fcs_flash_checker fcs_flash_checker_i (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .init_scan_req(init_scan_req), .init_setup(init_setup),
      .boot_section_limit(16'h000f), .app_section_limit(16'h001f), .last_program_address(16'h003f),
      .flash_req(flash_req), .flash_addr(flash_addr), .flash_valid(flash_valid), .flash_rdata(flash_rdata),
      .cpu_sleep(cpu_sleep), .cpu_stall(cpu_stall), .cpu_start_block(cpu_start_block), .nmi_req(nmi_req));
   fcs_flash_model fcs_flash_model_i (.core_clk(core_clk), .flash_req(flash_req), .flash_addr(flash_addr),
      .flash_valid(flash_valid), .flash_rdata(flash_rdata));
   // Word fetches must be spaced and may only come while the CPU is held off.
   always @(posedge core_clk) begin
      gap <= flash_req ? 1 : gap + 1;
      if (flash_req) nreq <= nreq + 1;
      if (flash_req && (gap < 3 || cpu_stall !== 1'b1)) begin
         n_fail = n_fail + 1;
         $display("mismatch fetch spacing expected 3 seen %0d", gap);
      end
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      // Answer flops settle by the falling edge and hold until the next rising edge, where waitrequest goes high again.
      forever begin
         @(negedge core_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      @(posedge core_clk);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd(input string what, input logic [1:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(what, exp, q);
   endtask
   task automatic idle();
      logic [7:0] q;
      q = 8'h01;
      while (q[0] !== 1'b0) bus(1'b0, 2'h2, 8'h00, q);
   endtask
   task automatic rst();
      sys_rst <= 1'b1;
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
   endtask
   function automatic logic [15:0] crc_of(input int n);
      logic [15:0] c;
      c = 16'hffff;
      for (int i = 0; i < n; i++)
         for (int b = 7; b >= 0; b--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ fcs_flash_model_i.mem[i][b]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction
   task automatic place(input int lim);
      logic [15:0] c;
      c = crc_of(lim - 1);
      fcs_flash_model_i.mem[lim - 1] = c[15:8];
      fcs_flash_model_i.mem[lim] = c[7:0];
   endtask
   // ********************************************************************
   // Scenarios
   // ********************************************************************
   task automatic t_regs();
      rd("control", 2'h0, 8'h00);
      rd("setup", 2'h1, 8'h00);
      rd("state", 2'h2, 8'h02);
      rd("unmapped", 2'h3, 8'h00);
      $display("register reset test done");
   endtask
   task automatic t_scan(input logic [1:0] sec, input int lim);
      int n0;
      n0 = nreq;
      wr(2'h1, {6'h00, sec});
      wr(2'h0, 8'h01);
      repeat (3) @(posedge core_clk);
      chk("stall", 8'h01, {7'h00, cpu_stall});
      rd("busy", 2'h2, 8'h01);
      wr(2'h1, 8'h03);
      idle();
      rd("pass", 2'h2, 8'h02);
      rd("enable kept", 2'h0, 8'h01);
      rd("setup kept", 2'h1, {6'h00, sec});
      chk("words", 8'((lim + 1) / 2), 8'(nreq - n0));
      chk("nmi", 8'h00, {7'h00, nmi_req});
      $display("scan of section %0d done", sec);
   endtask
   task automatic t_sleep();
      int n0;
      wr(2'h0, 8'h01);
      cpu_sleep <= 1'b1;
      n0 = nreq;
      repeat (30) @(posedge core_clk);
      chk("sleep words", 8'h00, 8'(nreq - n0));
      cpu_sleep <= 1'b0;
      idle();
      rd("pass after wake", 2'h2, 8'h02);
      $display("sleep test done");
   endtask
   task automatic t_sreset();
      wr(2'h1, 8'h02);
      wr(2'h0, 8'h01);
      repeat (3) @(posedge core_clk);
      wr(2'h0, 8'h80);
      rd("control cleared", 2'h0, 8'h00);
      rd("setup cleared", 2'h1, 8'h00);
      wr(2'h0, 8'h02);
      wr(2'h0, 8'h80);
      rd("nmi enable kept", 2'h0, 8'h02);
      $display("self reset test done");
   endtask
   task automatic t_fail();
      fcs_flash_model_i.mem[3] ^= 8'h01;
      wr(2'h1, 8'h02);
      wr(2'h0, 8'h03);
      idle();
      rd("fail state", 2'h2, 8'h00);
      chk("nmi raised", 8'h01, {7'h00, nmi_req});
      wr(2'h0, 8'h80);
      wr(2'h1, 8'h01);
      rd("control locked", 2'h0, 8'h03);
      rd("setup locked", 2'h1, 8'h02);
      chk("nmi held", 8'h01, {7'h00, nmi_req});
      fcs_flash_model_i.mem[3] ^= 8'h01;
      rst();
      chk("nmi cleared", 8'h00, {7'h00, nmi_req});
      rd("control after reset", 2'h0, 8'h00);
      $display("failure test done");
   endtask
   task automatic t_init(input logic bad);
      fcs_flash_model_i.mem[5] ^= {7'h00, bad};
      init_scan_req <= 1'b1;
      rst();
      repeat (4) @(posedge core_clk);
      idle();
      init_scan_req <= 1'b0;
      chk("start block", {7'h00, bad}, {7'h00, cpu_start_block});
      if (!bad) rd("init control", 2'h0, 8'h01);
      if (!bad) rd("init setup", 2'h1, 8'h11);
      fcs_flash_model_i.mem[5] ^= {7'h00, bad};
      $display("reset time scan test done");
   endtask
   initial begin
      for (int i = 0; i < 64; i++) fcs_flash_model_i.mem[i] = 8'(i * 37 + 11);
      place(15);
      place(31);
      place(63);
      rst();
      t_regs();
      t_scan(2'h2, 15);
      t_scan(2'h1, 31);
      t_scan(2'h0, 63);
      t_sleep();
      t_sreset();
      t_fail();
      t_init(1'b0);
      t_init(1'b1);
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      wrap_up();
   end
endmodule
